/* hw/async_request_node_filter.sv */
`timescale 1ns/10ps
`include "arnf_map.svh"
// Functional notes
// - config ROM quadlet reads, IRM accesses skip filters
// - link enabled: first 1K ROM open
// - responses pass, no filter applied
// - request bit 0: no ack, discard
// - request bit 1: accept and route
// - offsets above physical limit go to DMA
// - DMA context disabled: request ignored
// - node bit admits bus 3FFh or local
// - accept-all bit 31 admits every requester
// - bus reset clears request node bits only
// - request nodes 62:32 high, 31:0 low
// - set and clear addresses read state
// - physical range: bit 0 goes DMA
// - physical bit 1 goes to physical unit
// - lock, extended block always go DMA
// - phys node bit admits 3FFh or local
// - all-buses bit admits foreign bus numbers
// - physical rejects to DMA if enabled
// - bus reset clears whole physical filter
// - physical nodes 62:32 high, 31:0 low
// - set writes ones set, clear clears
// - local bus number forced 3FFh on reset
module async_request_node_filter (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic bus_reset,
    input wire arnf_pkg::request_type rx_request,
    output arnf_pkg::decision_type decision
);

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    // per-node lookup; node 63 has no bit
    function automatic logic node_hit(input logic [31:0] hi, input logic [31:0] lo, input logic [5:0] node);
        logic [62:0] map;
        map = {hi[30:0], lo};
        if (node == `ARNF_NODE_NONE) begin
            node_hit = 1'b0;
        end else begin
            node_hit = map[node];
        end
    endfunction

    function automatic logic in_window(input logic [47:0] a, input logic [47:0] lo, input logic [47:0] hi);
        in_window = (a >= lo) && (a <= hi);
    endfunction

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    logic [31:0] req_hi_q;
    logic [31:0] req_hi_d;
    logic [31:0] req_lo_q;
    logic [31:0] req_lo_d;
    logic [31:0] phy_hi_q;
    logic [31:0] phy_hi_d;
    logic [31:0] phy_lo_q;
    logic [31:0] phy_lo_d;
    logic [1:0] ctrl_q;
    logic [1:0] ctrl_d;
    logic [9:0] bus_num_q;
    logic [9:0] bus_num_d;
    logic [31:0] prdata_q;
    logic [31:0] prdata_d;
    logic err_q;
    arnf_pkg::decision_type decision_q;
    arnf_pkg::decision_type decision_d;

    // ------------------------------------------------------------
    // apb decode
    // ------------------------------------------------------------
    wire setup_phase = psel && !penable;
    wire wr_take = psel && penable && pwrite;
    wire hit_req_hi_set = (paddr == `ARNF_REQ_HI_SET);
    wire hit_req_hi_clr = (paddr == `ARNF_REQ_HI_CLR);
    wire hit_req_lo_set = (paddr == `ARNF_REQ_LO_SET);
    wire hit_req_lo_clr = (paddr == `ARNF_REQ_LO_CLR);
    wire hit_phy_hi_set = (paddr == `ARNF_PHY_HI_SET);
    wire hit_phy_hi_clr = (paddr == `ARNF_PHY_HI_CLR);
    wire hit_phy_lo_set = (paddr == `ARNF_PHY_LO_SET);
    wire hit_phy_lo_clr = (paddr == `ARNF_PHY_LO_CLR);
    wire hit_ctrl = (paddr == `ARNF_LINK_CTRL);
    wire hit_bus = (paddr == `ARNF_BUS_NUMBER);
    wire hit_req_hi = hit_req_hi_set || hit_req_hi_clr;
    wire hit_req_lo = hit_req_lo_set || hit_req_lo_clr;
    wire hit_phy_hi = hit_phy_hi_set || hit_phy_hi_clr;
    wire hit_phy_lo = hit_phy_lo_set || hit_phy_lo_clr;
    wire mapped = hit_req_hi || hit_req_lo || hit_phy_hi || hit_phy_lo || hit_ctrl || hit_bus;

    // both addresses of a pair read the same state
    wire [31:0] bus_word = {16'h0000, bus_num_q, 6'h00};
    wire [31:0] read_mux = hit_req_hi ? req_hi_q :
                           hit_req_lo ? req_lo_q :
                           hit_phy_hi ? phy_hi_q :
                           hit_phy_lo ? phy_lo_q :
                           hit_ctrl ? {30'h0000_0000, ctrl_q} :
                           hit_bus ? bus_word : 32'h0000_0000;

    // ------------------------------------------------------------
    // filter register next state
    // ------------------------------------------------------------
    // bus reset outranks a software write in the same cycle
    always_comb begin
        req_hi_d = req_hi_q;
        req_lo_d = req_lo_q;
        phy_hi_d = phy_hi_q;
        phy_lo_d = phy_lo_q;
        ctrl_d = ctrl_q;
        bus_num_d = bus_num_q;
        if (wr_take) begin
            if (hit_req_hi_set) begin
                req_hi_d = req_hi_q | pwdata;
            end
            if (hit_req_hi_clr) begin
                req_hi_d = req_hi_q & ~pwdata;
            end
            if (hit_req_lo_set) begin
                req_lo_d = req_lo_q | pwdata;
            end
            if (hit_req_lo_clr) begin
                req_lo_d = req_lo_q & ~pwdata;
            end
            if (hit_phy_hi_set) begin
                phy_hi_d = phy_hi_q | pwdata;
            end
            if (hit_phy_hi_clr) begin
                phy_hi_d = phy_hi_q & ~pwdata;
            end
            if (hit_phy_lo_set) begin
                phy_lo_d = phy_lo_q | pwdata;
            end
            if (hit_phy_lo_clr) begin
                phy_lo_d = phy_lo_q & ~pwdata;
            end
            if (hit_ctrl) begin
                ctrl_d = pwdata[1:0];
            end
            if (hit_bus) begin
                bus_num_d = pwdata[`ARNF_BUSNUM_MSB:`ARNF_BUSNUM_LSB];
            end
        end
        if (bus_reset) begin
            req_hi_d = {req_hi_q[`ARNF_ALL_BIT], 31'h0000_0000};
            req_lo_d = `ARNF_FILTER_RESET;
            phy_hi_d = `ARNF_FILTER_RESET;
            phy_lo_d = `ARNF_FILTER_RESET;
            bus_num_d = `ARNF_BUS_WILDCARD;
        end
    end

    assign prdata_d = (setup_phase && !pwrite) ? read_mux : prdata_q;

    // ------------------------------------------------------------
    // admission decision
    // ------------------------------------------------------------
    wire [9:0] src_bus = rx_request.source_id[15:6];
    wire [5:0] src_node = rx_request.source_id[5:0];
    wire link_en = ctrl_q[`ARNF_LINK_EN_BIT];
    wire dma_en = ctrl_q[`ARNF_DMA_EN_BIT];
    wire bus_local = (src_bus == `ARNF_BUS_WILDCARD) || (src_bus == bus_num_q);
    wire in_rom = in_window(rx_request.offset, `ARNF_ROM_FIRST, `ARNF_ROM_LAST);
    wire in_irm = in_window(rx_request.offset, `ARNF_IRM_FIRST, `ARNF_IRM_LAST);
    wire bypass = (in_rom && rx_request.is_quadlet_read) || in_irm
                  || (in_rom && link_en);
    wire req_node_ok = bus_local && node_hit(req_hi_q, req_lo_q, src_node);
    wire req_ok = req_hi_q[`ARNF_ALL_BIT] || req_node_ok;
    wire in_phys = (rx_request.offset <= `ARNF_PHYS_LIMIT);
    wire phy_node_ok = bus_local && node_hit(phy_hi_q, phy_lo_q, src_node);
    wire phy_ok = phy_node_ok || (!bus_local && phy_hi_q[`ARNF_ALL_BIT]);
    wire force_dma = rx_request.is_lock || (rx_request.is_block && rx_request.ext_tcode_nonzero);
    wire arnf_pkg::route_type dma_or_ignore = dma_en ? arnf_pkg::route_dma : arnf_pkg::route_ignore;

    always_comb begin
        decision_d.valid = rx_request.valid;
        decision_d.source_id = rx_request.source_id;
        if (rx_request.is_response) begin
            decision_d.route = arnf_pkg::route_response;
        end else if (bypass) begin
            decision_d.route = arnf_pkg::route_autonomous;
        end else if (!req_ok) begin
            decision_d.route = arnf_pkg::route_drop;
        end else if (!in_phys || force_dma) begin
            decision_d.route = dma_or_ignore;
        end else if (phy_ok) begin
            decision_d.route = arnf_pkg::route_phys;
        end else begin
            decision_d.route = dma_or_ignore;
        end
    end

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            req_hi_q <= `ARNF_FILTER_RESET;
            req_lo_q <= `ARNF_FILTER_RESET;
            phy_hi_q <= `ARNF_FILTER_RESET;
            phy_lo_q <= `ARNF_FILTER_RESET;
            ctrl_q <= `ARNF_CTRL_RESET;
            bus_num_q <= `ARNF_BUS_WILDCARD;
        end else begin
            req_hi_q <= req_hi_d;
            req_lo_q <= req_lo_d;
            phy_hi_q <= phy_hi_d;
            phy_lo_q <= phy_lo_d;
            ctrl_q <= ctrl_d;
            bus_num_q <= bus_num_d;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_q <= 32'h0000_0000;
            err_q <= 1'b0;
            decision_q <= '0;
        end else begin
            prdata_q <= prdata_d;
            err_q <= setup_phase ? !mapped : err_q;
            decision_q <= decision_d;
        end
    end

    assign prdata = prdata_q;
    assign pready = 1'b1;
    assign pslverr = psel && penable && err_q;
    assign decision = decision_q;

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    a_response_pass: assert property (@(posedge pclk) disable iff (!presetn)
        rx_request.valid && rx_request.is_response |=> decision.route == arnf_pkg::route_response)
        else $error("response not passed through");

    a_drop_unknown: assert property (@(posedge pclk) disable iff (!presetn)
        rx_request.valid && !rx_request.is_response && !bypass && !req_ok
        |=> decision.valid && decision.route == arnf_pkg::route_drop)
        else $error("unadmitted request not dropped");

    a_accept_all: assert property (@(posedge pclk) disable iff (!presetn)
        rx_request.valid && !rx_request.is_response && req_hi_q[31]
        |=> decision.route != arnf_pkg::route_drop)
        else $error("accept-all requester dropped");

    a_node63_none: assert property (@(posedge pclk) disable iff (!presetn)
        rx_request.valid && !rx_request.is_response && !bypass && !req_hi_q[31]
        && rx_request.source_id[5:0] == 6'h3f |=> decision.route == arnf_pkg::route_drop)
        else $error("node 63 admitted by node bit");

    a_high_offset_dma: assert property (@(posedge pclk) disable iff (!presetn)
        rx_request.valid && !rx_request.is_response && !bypass && req_ok && !in_phys
        |=> decision.route == ($past(dma_en) ? arnf_pkg::route_dma : arnf_pkg::route_ignore))
        else $error("high offset misrouted");

    a_lock_to_dma: assert property (@(posedge pclk) disable iff (!presetn)
        rx_request.valid && !rx_request.is_response && !bypass && req_ok && rx_request.is_lock
        |=> decision.route != arnf_pkg::route_phys)
        else $error("lock served physically");

    a_phys_route: assert property (@(posedge pclk) disable iff (!presetn)
        rx_request.valid && !rx_request.is_response && !bypass && req_ok && in_phys && !force_dma && phy_ok
        |=> decision.route == arnf_pkg::route_phys)
        else $error("physical request not sent to physical unit");

    a_rom_bypass: assert property (@(posedge pclk) disable iff (!presetn)
        rx_request.valid && !rx_request.is_response && in_rom && rx_request.is_quadlet_read
        |=> decision.route == arnf_pkg::route_autonomous)
        else $error("rom quadlet read filtered");

    a_busrst_req: assert property (@(posedge pclk) disable iff (!presetn)
        bus_reset |=> req_lo_q == 32'h0 && req_hi_q[30:0] == 31'h0 && req_hi_q[31] == $past(req_hi_q[31]))
        else $error("bus reset request filter wrong");

    a_busrst_phys: assert property (@(posedge pclk) disable iff (!presetn)
        bus_reset |=> phy_hi_q == 32'h0 && phy_lo_q == 32'h0 && bus_num_q == 10'h3ff)
        else $error("bus reset physical filter or bus number wrong");

    a_write_set: assert property (@(posedge pclk) disable iff (!presetn)
        wr_take && hit_req_lo_set && !bus_reset |=> (req_lo_q & $past(pwdata)) == $past(pwdata))
        else $error("set write did not set bits");

    a_write_clear: assert property (@(posedge pclk) disable iff (!presetn)
        wr_take && hit_phy_lo_clr |=> (phy_lo_q & $past(pwdata)) == 32'h0)
        else $error("clear write did not clear bits");

    a_read_state: assert property (@(posedge pclk) disable iff (!presetn)
        setup_phase && !pwrite && hit_req_hi_clr |=> prdata == $past(req_hi_q))
        else $error("clear address read wrong");

    a_rom_link_open: assert property (@(posedge pclk) disable iff (!presetn)
        rx_request.valid && !rx_request.is_response && in_rom && link_en
        |=> decision.route == arnf_pkg::route_autonomous)
        else $error("rom window closed while link enabled");

    a_admit_accept: assert property (@(posedge pclk) disable iff (!presetn)
        rx_request.valid && !rx_request.is_response && !bypass && req_ok
        |=> decision.valid && decision.route != arnf_pkg::route_drop)
        else $error("admitted request dropped");

    a_dma_off_ignore: assert property (@(posedge pclk) disable iff (!presetn)
        rx_request.valid && !rx_request.is_response && !bypass && req_ok && !dma_en
        |=> decision.route != arnf_pkg::route_dma)
        else $error("request sent to disabled dma context");

    a_phys_reject_dma: assert property (@(posedge pclk) disable iff (!presetn)
        rx_request.valid && !rx_request.is_response && !bypass && req_ok && in_phys && !phy_ok && dma_en
        |=> decision.route == arnf_pkg::route_dma)
        else $error("physical reject not sent to dma");

    a_block_ext_dma: assert property (@(posedge pclk) disable iff (!presetn)
        rx_request.valid && !rx_request.is_response && !bypass && req_ok && in_phys && dma_en
        && rx_request.is_block && rx_request.ext_tcode_nonzero |=> decision.route == arnf_pkg::route_dma)
        else $error("extended block served physically");

    a_phys_node_low: assert property (@(posedge pclk) disable iff (!presetn)
        rx_request.valid && !rx_request.is_response && !bypass && req_ok && in_phys && !force_dma
        && bus_local && !src_node[5] && phy_lo_q[src_node[4:0]] |=> decision.route == arnf_pkg::route_phys)
        else $error("listed physical node not served");

    a_phys_all_buses: assert property (@(posedge pclk) disable iff (!presetn)
        rx_request.valid && !rx_request.is_response && !bypass && req_ok && in_phys && !force_dma
        && !bus_local && phy_hi_q[31] |=> decision.route == arnf_pkg::route_phys)
        else $error("remote bus physical request not served");

    a_phys_foreign_no: assert property (@(posedge pclk) disable iff (!presetn)
        rx_request.valid && !rx_request.is_response && !bypass && req_ok && !bus_local && !phy_hi_q[31]
        |=> decision.route != arnf_pkg::route_phys)
        else $error("remote bus served without all-buses bit");

    a_req_node_low: assert property (@(posedge pclk) disable iff (!presetn)
        rx_request.valid && !rx_request.is_response && !bypass && bus_local && !src_node[5]
        && req_lo_q[src_node[4:0]] |=> decision.route != arnf_pkg::route_drop)
        else $error("listed requester dropped");

    a_req_foreign_drop: assert property (@(posedge pclk) disable iff (!presetn)
        rx_request.valid && !rx_request.is_response && !bypass && !req_hi_q[31] && !bus_local
        |=> decision.route == arnf_pkg::route_drop)
        else $error("remote bus requester admitted by node bit");

    a_hw_reset_clear: assert property (@(posedge pclk) disable iff (!presetn)
        $rose(presetn) |-> req_hi_q == 32'h0 && req_lo_q == 32'h0 && phy_hi_q == 32'h0 && phy_lo_q == 32'h0)
        else $error("filters not clear after reset");

    a_read_phys_set: assert property (@(posedge pclk) disable iff (!presetn)
        setup_phase && !pwrite && hit_phy_lo_set |=> prdata == $past(phy_lo_q))
        else $error("set address read wrong");

    c_phys: cover property (@(posedge pclk) disable iff (!presetn)
        decision.valid && decision.route == arnf_pkg::route_phys);
    c_drop: cover property (@(posedge pclk) disable iff (!presetn)
        decision.valid && decision.route == arnf_pkg::route_drop);
    c_ignore: cover property (@(posedge pclk) disable iff (!presetn)
        decision.valid && decision.route == arnf_pkg::route_ignore);
    c_busrst: cover property (@(posedge pclk) disable iff (!presetn) bus_reset && req_hi_q[31]);
    c_autonomous: cover property (@(posedge pclk) disable iff (!presetn)
        decision.valid && decision.route == arnf_pkg::route_autonomous);

endmodule

/* include/arnf_map.svh */
`ifndef ARNF_MAP_SVH
`define ARNF_MAP_SVH

// register byte offsets
`define ARNF_REQ_HI_SET 12'h100
`define ARNF_REQ_HI_CLR 12'h104
`define ARNF_REQ_LO_SET 12'h108
`define ARNF_REQ_LO_CLR 12'h10c
`define ARNF_PHY_HI_SET 12'h110
`define ARNF_PHY_HI_CLR 12'h114
`define ARNF_PHY_LO_SET 12'h118
`define ARNF_PHY_LO_CLR 12'h11c
`define ARNF_LINK_CTRL 12'h120
`define ARNF_BUS_NUMBER 12'h124

// field positions
`define ARNF_ALL_BIT 31
`define ARNF_LINK_EN_BIT 0
`define ARNF_DMA_EN_BIT 1
`define ARNF_BUSNUM_LSB 6
`define ARNF_BUSNUM_MSB 15

// reset values and the no-bit node number
`define ARNF_FILTER_RESET 32'h0000_0000
`define ARNF_CTRL_RESET 2'h0
`define ARNF_BUS_WILDCARD 10'h3ff
`define ARNF_NODE_NONE 6'h3f

// address windows
`define ARNF_PHYS_LIMIT 48'h0000_ffff_ffff
`define ARNF_ROM_FIRST 48'hffff_f000_0400
`define ARNF_ROM_LAST 48'hffff_f000_07ff
`define ARNF_IRM_FIRST 48'hffff_f000_0220
`define ARNF_IRM_LAST 48'hffff_f000_022f

`endif

/* include/arnf_pkg.sv */
package arnf_pkg;

    typedef enum logic [2:0] {
        route_drop = 3'h0,
        route_ignore = 3'h1,
        route_dma = 3'h3,
        route_phys = 3'h2,
        route_autonomous = 3'h6,
        route_response = 3'h7
    } route_type;

    typedef struct packed {
        logic valid;
        logic is_response;
        logic is_quadlet_read;
        logic is_lock;
        logic is_block;
        logic ext_tcode_nonzero;
        logic [15:0] source_id;
        logic [47:0] offset;
    } request_type;

    typedef struct packed {
        logic valid;
        route_type route;
        logic [15:0] source_id;
    } decision_type;

endpackage

/* verification/remote_node_model.sv */
`timescale 1ns/10ps
module remote_node_model (
    input wire logic pclk,
    output arnf_pkg::request_type rx_request
);
    initial rx_request = '0;

    // kind = {response, quadlet read, lock, block, extended code}
    task automatic send(input logic [4:0] kind, input logic [15:0] src, input logic [47:0] off);
        arnf_pkg::request_type r;
        r = '0;
        r.valid = 1'b1;
        {r.is_response, r.is_quadlet_read, r.is_lock, r.is_block, r.ext_tcode_nonzero} = kind;
        r.source_id = src;
        r.offset = off;
        @(posedge pclk);
        rx_request <= r;
        @(posedge pclk);
        // idle lines scrambled so stale fields never look valid
        r = ~r;
        r.valid = 1'b0;
        rx_request <= r;
    endtask
endmodule

/* verification/tb_async_request_node_filter.sv */
`timescale 1ns/10ps
`include "arnf_map.svh"
module tb_async_request_node_filter;
    logic pclk, presetn, psel, penable, pwrite, bus_reset, pready, pslverr, e;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, q;
    arnf_pkg::request_type rx_request;
    arnf_pkg::decision_type decision;
    int err_total, comparisons;
    logic [47:0] high_off = 48'h0001_0000_0000;
    logic [47:0] phys_off = 48'h0000_0000_1000;

    async_request_node_filter async_request_node_filter_i (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .bus_reset(bus_reset), .rx_request(rx_request), .decision(decision));
    remote_node_model remote_node_model_i (.pclk(pclk), .rx_request(rx_request));

    initial begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end

    // ----------------------------------------
    // shared tasks
    // ----------------------------------------
    task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
        comparisons++;
        if (got !== exp) begin
            err_total++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        // only the watchdog ends a wait that never sees pready
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic rd_chk(input string name, input logic [11:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        check(name, exp, q);
        check({name, " error"}, 32'h0, {31'h0, e});
    endtask

    task automatic req_chk(input string name, input logic [4:0] kind, input logic [15:0] src,
                           input logic [47:0] off, input arnf_pkg::route_type exp);
        remote_node_model_i.send(kind, src, off);
        #1;
        check(name, {28'h0, 1'b1, exp}, {28'h0, decision.valid, decision.route});
        check({name, " source"}, {16'h0, src}, {16'h0, decision.source_id});
    endtask

    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task automatic test_reset;
        for (int i = 0; i < 8; i++) begin
            rd_chk("filter reset", 12'(12'h100 + 4 * i), 32'h0);
        end
        rd_chk("bus number reset", `ARNF_BUS_NUMBER, 32'h0000_ffc0);
        apb(1'b0, 12'h200, 32'h0);
        check("unmapped error", 32'h1, {31'h0, e});
        $display("test_reset done");
    endtask

    task automatic test_setclr;
        apb(1'b1, `ARNF_REQ_LO_SET, 32'h8000_0021);
        rd_chk("req lo via clear", `ARNF_REQ_LO_CLR, 32'h8000_0021);
        apb(1'b1, `ARNF_REQ_LO_CLR, 32'h8000_0001);
        rd_chk("req lo via set", `ARNF_REQ_LO_SET, 32'h0000_0020);
        apb(1'b1, `ARNF_PHY_HI_SET, 32'h0000_0100);
        rd_chk("phys hi via clear", `ARNF_PHY_HI_CLR, 32'h0000_0100);
        $display("test_setclr done");
    endtask

    task automatic test_admit;
        req_chk("unlisted node", 5'h00, {10'h3ff, 6'd6}, high_off, arnf_pkg::route_drop);
        req_chk("dma disabled", 5'h00, {10'h3ff, 6'd5}, high_off, arnf_pkg::route_ignore);
        apb(1'b1, `ARNF_LINK_CTRL, 32'h0000_0002);
        req_chk("high offset", 5'h00, {10'h3ff, 6'd5}, high_off, arnf_pkg::route_dma);
        apb(1'b1, `ARNF_BUS_NUMBER, 32'h0000_0140);
        req_chk("local bus", 5'h00, {10'd5, 6'd5}, high_off, arnf_pkg::route_dma);
        req_chk("foreign bus", 5'h00, {10'd7, 6'd5}, high_off, arnf_pkg::route_drop);
        req_chk("node 63", 5'h00, {10'h3ff, 6'd63}, high_off, arnf_pkg::route_drop);
        apb(1'b1, `ARNF_REQ_HI_SET, 32'h0000_0100);
        req_chk("node 40", 5'h00, {10'h3ff, 6'd40}, high_off, arnf_pkg::route_dma);
        apb(1'b1, `ARNF_REQ_HI_SET, 32'h8000_0000);
        req_chk("accept all", 5'h00, {10'd7, 6'd9}, high_off, arnf_pkg::route_dma);
        $display("test_admit done");
    endtask

    task automatic test_phys;
        req_chk("phys bit clear", 5'h00, {10'h3ff, 6'd5}, phys_off, arnf_pkg::route_dma);
        apb(1'b1, `ARNF_PHY_LO_SET, 32'h0000_0020);
        req_chk("phys bit set", 5'h00, {10'd5, 6'd5}, phys_off, arnf_pkg::route_phys);
        req_chk("phys node 40", 5'h00, {10'h3ff, 6'd40}, phys_off, arnf_pkg::route_phys);
        req_chk("phys lock", 5'h04, {10'h3ff, 6'd5}, phys_off, arnf_pkg::route_dma);
        req_chk("phys block ext", 5'h03, {10'h3ff, 6'd5}, phys_off, arnf_pkg::route_dma);
        req_chk("foreign no all", 5'h00, {10'd7, 6'd5}, phys_off, arnf_pkg::route_dma);
        apb(1'b1, `ARNF_PHY_HI_SET, 32'h8000_0000);
        req_chk("foreign all", 5'h00, {10'd7, 6'd9}, phys_off, arnf_pkg::route_phys);
        req_chk("local no bit", 5'h00, {10'd5, 6'd9}, phys_off, arnf_pkg::route_dma);
        apb(1'b1, `ARNF_LINK_CTRL, 32'h0000_0000);
        req_chk("reject dma off", 5'h00, {10'h3ff, 6'd6}, phys_off, arnf_pkg::route_ignore);
        $display("test_phys done");
    endtask

    task automatic test_bypass;
        apb(1'b1, `ARNF_REQ_HI_CLR, 32'h8000_0000);
        req_chk("response", 5'h10, {10'd7, 6'd9}, high_off, arnf_pkg::route_response);
        req_chk("rom quadlet", 5'h08, {10'd7, 6'd9}, 48'hffff_f000_0400, arnf_pkg::route_autonomous);
        req_chk("irm access", 5'h02, {10'd7, 6'd9}, 48'hffff_f000_0224, arnf_pkg::route_autonomous);
        req_chk("rom link off", 5'h02, {10'd7, 6'd9}, 48'hffff_f000_07fc, arnf_pkg::route_drop);
        apb(1'b1, `ARNF_LINK_CTRL, 32'h0000_0001);
        req_chk("rom link on", 5'h02, {10'd7, 6'd9}, 48'hffff_f000_07fc, arnf_pkg::route_autonomous);
        $display("test_bypass done");
    endtask

    task automatic test_bus_reset;
        apb(1'b1, `ARNF_REQ_HI_SET, 32'h8000_0000);
        apb(1'b1, `ARNF_REQ_LO_SET, 32'h0000_0003);
        @(posedge pclk);
        bus_reset <= 1'b1;
        @(posedge pclk);
        bus_reset <= 1'b0;
        rd_chk("req hi after reset", `ARNF_REQ_HI_SET, 32'h8000_0000);
        rd_chk("req lo after reset", `ARNF_REQ_LO_CLR, 32'h0);
        rd_chk("phys hi after reset", `ARNF_PHY_HI_SET, 32'h0);
        rd_chk("phys lo after reset", `ARNF_PHY_LO_CLR, 32'h0);
        rd_chk("bus number after reset", `ARNF_BUS_NUMBER, 32'h0000_ffc0);
        $display("test_bus_reset done");
    endtask

    // ----------------------------------------
    // run control
    // ----------------------------------------
    task automatic finish_test;
        $display("comparisons %0d mismatches %0d", comparisons, err_total);
        if (err_total == 0 && comparisons > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    initial begin
        #200000;
        err_total++;
        finish_test();
    end

    initial begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h0;
        pwdata = 32'h0;
        bus_reset = 1'b0;
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        test_reset();
        test_setclr();
        test_admit();
        test_phys();
        test_bypass();
        test_bus_reset();
        finish_test();
    end
endmodule
